// >>> hw/smrf_socket_mode_filter.sv
// Socket mode registers, receive filter and acknowledge timing
// ==========================================================================
//
// Design decision made here: the Wishbone slave port.
`include "smrf_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module smrf_socket_mode_filter #(
    parameter int NUM_SOCKETS = 8,
    parameter logic [7:0] CHIP_VERSION = 8'h5A, // Arbitrary identification value
    parameter int RETRY_UNIT_CYCLES = `SMRF_RETRY_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Received frame descriptor
    input wire logic frame_valid_i,
    input wire smrf_pkg::smrf_frame_t frame_i,
    output logic frame_accept_o,
    output logic frame_drop_o,
    // TCP data arrival and acknowledge request
    input wire logic tcp_data_rx_i,
    input wire logic [2:0] tcp_socket_i,
    output logic ack_send_o,
    output logic [2:0] ack_socket_o,
    // Per-socket configuration, chosen by cfg_socket_i
    input wire logic [2:0] cfg_socket_i,
    output smrf_pkg::smrf_sock_cfg_t cfg_o
);

    // ======================================================================
    // Parameter checks; the socket index field is three bits wide
    if (NUM_SOCKETS != 8) begin : g_bad_sockets
        $error("NUM_SOCKETS must be 8");
    end
    if (RETRY_UNIT_CYCLES < 1) begin : g_bad_unit
        $error("RETRY_UNIT_CYCLES must be at least 1");
    end

    // ======================================================================
    // Bus decode
    logic [7:0] socket_mode_reg [NUM_SOCKETS];
    logic [47:0] own_mac;
    logic [15:0] retry_time_value;
    logic [7:0] drop_count;
    logic [7:0] accept_count;
    logic req;
    logic [9:0] word_idx;
    logic [2:0] socket_index;
    logic [5:0] reg_idx;
    logic wr_lane0;
    logic hit_mode;
    logic hit_common;

    // Ack is registered and masks req, so a held strobe is taken every other cycle
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign word_idx = wb_adr_i[11:2];
    assign socket_index = word_idx[8:6];
    assign reg_idx = word_idx[5:0];
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
    assign hit_mode = !word_idx[9] && reg_idx == 6'(`SMRF_SOCKET_MODE_IDX);
    assign hit_common = word_idx[9:6] == 4'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // ======================================================================
    // Socket mode registers
    // Only lane 0 carries the mode byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_SOCKETS; i++) begin
                socket_mode_reg[i] <= `SMRF_SOCKET_MODE_RESET;
            end
        end else if (wr_lane0 && hit_mode) begin
            socket_mode_reg[socket_index] <= wb_dat_i[7:0];
        end
    end

    // Own MAC and retry time live in socket 0 space only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own_mac <= 48'h0000_0000_0000;
        end else if (req && wb_we_i && hit_common) begin
            if (reg_idx == 6'(`SMRF_OWN_MAC_LO_IDX)) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) own_mac[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
            if (reg_idx == 6'(`SMRF_OWN_MAC_HI_IDX)) begin
                for (int b = 0; b < 2; b++) begin
                    if (wb_sel_i[b]) own_mac[32 + b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retry_time_value <= `SMRF_RETRY_TIME_RESET;
        end else if (req && wb_we_i && hit_common && reg_idx == 6'(`SMRF_RETRY_TIME_IDX)) begin
            for (int b = 0; b < 2; b++) begin
                if (wb_sel_i[b]) retry_time_value[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    end

    // ======================================================================
    // Read data; unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            wb_dat_o <= 32'h0000_0000;
            if (hit_mode) begin
                wb_dat_o <= {24'h00_0000, socket_mode_reg[socket_index]};
            end else if (hit_common) begin
                unique case (reg_idx)
                    6'(`SMRF_CHIP_VERSION_IDX): wb_dat_o <= {24'h00_0000, CHIP_VERSION};
                    6'(`SMRF_STATUS_IDX): wb_dat_o <= {16'h0000, drop_count, accept_count};
                    6'(`SMRF_OWN_MAC_LO_IDX): wb_dat_o <= own_mac[31:0];
                    6'(`SMRF_OWN_MAC_HI_IDX): wb_dat_o <= {16'h0000, own_mac[47:32]};
                    6'(`SMRF_RETRY_TIME_IDX): wb_dat_o <= {16'h0000, retry_time_value};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ======================================================================
    // Receive filter
    logic [7:0] rx_mode;
    logic [3:0] rx_proto;
    logic next_accept;
    logic own_hit;

    assign rx_mode = socket_mode_reg[frame_i.socket];
    assign rx_proto = rx_mode[`SMRF_PROTO_MSB:0];
    assign own_hit = frame_i.dest_mac == own_mac;

    // Closed and unknown protocols drop every frame
    always_comb begin
        next_accept = 1'b0;
        unique case (rx_proto)
            `SMRF_PROTO_UDP: begin
                next_accept = 1'b1;
                if (rx_mode[`SMRF_BIT_BCAST_BLOCK] && frame_i.is_broadcast) next_accept = 1'b0;
                if (frame_i.is_multicast && !rx_mode[`SMRF_BIT_MULTI]) next_accept = 1'b0;
                if (rx_mode[`SMRF_BIT_MULTI] && rx_mode[`SMRF_BIT_OPT4] && frame_i.is_unicast_ip) begin
                    next_accept = 1'b0;
                end
            end
            `SMRF_PROTO_RAW: begin
                next_accept = 1'b1;
                if (rx_mode[`SMRF_BIT_MULTI] && !frame_i.is_broadcast && !own_hit) begin
                    next_accept = 1'b0;
                end
                if (rx_mode[`SMRF_BIT_BCAST_BLOCK] && frame_i.is_broadcast) next_accept = 1'b0;
                if (rx_mode[`SMRF_BIT_OPT5] && frame_i.is_multicast) next_accept = 1'b0;
                if (rx_mode[`SMRF_BIT_OPT4] && frame_i.is_ipv6) next_accept = 1'b0;
            end
            `SMRF_PROTO_TCP: next_accept = !frame_i.is_broadcast && !frame_i.is_multicast;
            default: next_accept = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_accept_o <= 1'b0;
            frame_drop_o <= 1'b0;
        end else begin
            frame_accept_o <= frame_valid_i && next_accept;
            frame_drop_o <= frame_valid_i && !next_accept;
        end
    end

    // Saturating counters show the filter at work
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accept_count <= 8'h00;
        end else if (frame_valid_i && next_accept && accept_count != 8'hFF) begin
            accept_count <= accept_count + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drop_count <= 8'h00;
        end else if (frame_valid_i && !next_accept && drop_count != 8'hFF) begin
            drop_count <= drop_count + 8'h01;
        end
    end

    // ======================================================================
    // Acknowledge timing; one pending ack at a time, later data rides along
    // Unit counter is 32 bits so any divider parameter fits
    localparam logic [31:0] UNIT_CYCLES = 32'(RETRY_UNIT_CYCLES);
    smrf_pkg::smrf_ack_state_t ack_state;
    logic [31:0] unit_cnt;
    logic [15:0] unit_left;
    logic [7:0] tcp_mode;
    logic tcp_is_tcp;

    assign tcp_mode = socket_mode_reg[tcp_socket_i];
    assign tcp_is_tcp = tcp_mode[`SMRF_PROTO_MSB:0] == `SMRF_PROTO_TCP;
    assign ack_send_o = ack_state == smrf_pkg::SMRF_ACK_SEND;

    // Socket of the pending acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_socket_o <= 3'h0;
        end else if (ack_state == smrf_pkg::SMRF_ACK_IDLE && tcp_data_rx_i && tcp_is_tcp) begin
            ack_socket_o <= tcp_socket_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_state <= smrf_pkg::SMRF_ACK_IDLE;
            unit_cnt <= 32'h0000_0000;
            unit_left <= 16'h0000;
        end else begin
            unique case (ack_state)
                smrf_pkg::SMRF_ACK_IDLE: begin
                    if (tcp_data_rx_i && tcp_is_tcp) begin
                        unit_cnt <= 32'h0000_0000;
                        unit_left <= retry_time_value;
                        if (tcp_mode[`SMRF_BIT_OPT5] || retry_time_value == 16'h0000) begin
                            ack_state <= smrf_pkg::SMRF_ACK_SEND;
                        end else begin
                            ack_state <= smrf_pkg::SMRF_ACK_WAIT;
                        end
                    end
                end
                smrf_pkg::SMRF_ACK_WAIT: begin
                    if (unit_cnt == UNIT_CYCLES - 32'h0000_0001) begin
                        unit_cnt <= 32'h0000_0000;
                        unit_left <= unit_left - 16'h0001;
                        if (unit_left == 16'h0001) ack_state <= smrf_pkg::SMRF_ACK_SEND;
                    end else begin
                        unit_cnt <= unit_cnt + 32'h0000_0001;
                    end
                end
                smrf_pkg::SMRF_ACK_SEND: ack_state <= smrf_pkg::SMRF_ACK_IDLE;
                default: ack_state <= smrf_pkg::SMRF_ACK_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Configuration view for the protocol engine
    // Registered view costs a cycle but keeps the engine off the bus timing
    logic [7:0] cfg_mode;
    logic cfg_multi;

    assign cfg_mode = socket_mode_reg[cfg_socket_i];
    assign cfg_multi = cfg_mode[`SMRF_PROTO_MSB:0] == `SMRF_PROTO_UDP && cfg_mode[`SMRF_BIT_MULTI];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o.proto <= cfg_mode[`SMRF_PROTO_MSB:0];
            cfg_o.multicast_enable <= cfg_multi;
            cfg_o.igmp_version_one <= cfg_multi && cfg_mode[`SMRF_BIT_OPT5];
        end
    end

endmodule : smrf_socket_mode_filter
`default_nettype wire

// >>> include/smrf_defs.svh
// Register offsets, field positions, reset values and timing counts of the socket mode filter
`ifndef SMRF_DEFS_SVH
`define SMRF_DEFS_SVH

// ==========================================================================
// Register map (byte address = index * 4)
`define SMRF_SOCKET_MODE_IDX 8'h00
`define SMRF_CHIP_VERSION_IDX 8'h39
`define SMRF_SOCKET_STRIDE 8'h40
// Own additions: frame classifier and acknowledge timing registers
`define SMRF_STATUS_IDX 8'h3A
`define SMRF_OWN_MAC_LO_IDX 8'h3B
`define SMRF_OWN_MAC_HI_IDX 8'h3C
`define SMRF_RETRY_TIME_IDX 8'h3D

// ==========================================================================
// Socket mode fields
`define SMRF_BIT_MULTI 7
`define SMRF_BIT_BCAST_BLOCK 6
`define SMRF_BIT_OPT5 5
`define SMRF_BIT_OPT4 4
`define SMRF_PROTO_MSB 3
`define SMRF_SOCKET_MODE_RESET 8'h00
`define SMRF_PROTO_CLOSED 4'h0
`define SMRF_PROTO_TCP 4'h1
`define SMRF_PROTO_UDP 4'h2
`define SMRF_PROTO_RAW 4'h4

// ==========================================================================
// Timing: retry unit is 0.1 ms
`define SMRF_RETRY_UNIT_NS 100000
`define SMRF_CLK_PERIOD_NS 10
`define SMRF_RETRY_UNIT_CYCLES (`SMRF_RETRY_UNIT_NS / `SMRF_CLK_PERIOD_NS)
`define SMRF_RETRY_TIME_RESET 16'h07D0

`endif

// >>> include/smrf_pkg.sv
// Types shared by the socket mode filter
`default_nettype none
package smrf_pkg;

    typedef enum logic [1:0] {
        SMRF_ACK_IDLE = 2'b00,
        SMRF_ACK_WAIT = 2'b01,
        SMRF_ACK_SEND = 2'b10
    } smrf_ack_state_t;

    // Descriptor of one received frame, from the receive parser
    typedef struct packed {
        logic [2:0] socket;
        logic [47:0] dest_mac;
        logic is_broadcast;
        logic is_multicast;
        logic is_ipv6;
        logic is_unicast_ip;
    } smrf_frame_t;

    // Per-socket options handed to the protocol engine
    typedef struct packed {
        logic [3:0] proto;
        logic multicast_enable;
        logic igmp_version_one;
    } smrf_sock_cfg_t;

endpackage : smrf_pkg
`default_nettype wire

// >>> test/smrf_socket_mode_filter_chk.sv
// Port checker for the socket mode filter
`timescale 1ns/10ps
`default_nettype none
module smrf_socket_mode_filter_chk #(
    parameter logic [7:0] CHIP_VERSION = 8'h5A
) (
    // Clock and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Frames
    input wire logic frame_valid_i,
    input wire smrf_pkg::smrf_frame_t frame_i,
    input wire logic frame_accept_o,
    input wire logic frame_drop_o,
    // Ack and view
    input wire logic ack_send_o,
    input wire logic [2:0] cfg_socket_i,
    input wire smrf_pkg::smrf_sock_cfg_t cfg_o
);
    // ====================
    // Helpers
    logic [2:0] prev_sock;
    logic hit;
    always_ff @(posedge clk_i) begin
        prev_sock <= cfg_socket_i;
    end
    // The view lags one cycle, so only a settled view is trusted
    assign hit = frame_valid_i && prev_sock == cfg_socket_i && cfg_socket_i == frame_i.socket;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ====================
    // Properties
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    a_version_fixed: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 12'h0E4
        |=> wb_dat_o[7:0] == CHIP_VERSION)
        else $error("version read wrong");
    a_frame_verdict: assert property (frame_valid_i |=> frame_accept_o != frame_drop_o)
        else $error("frame verdict missing");
    a_frame_quiet: assert property (!frame_valid_i |=> !frame_accept_o && !frame_drop_o)
        else $error("verdict without frame");
    a_mcast_off: assert property (hit && cfg_o.proto == 4'h2 && !cfg_o.multicast_enable
        && frame_i.is_multicast |=> frame_drop_o)
        else $error("multicast not dropped");
    a_closed_drop: assert property (hit && cfg_o.proto == 4'h0 |=> frame_drop_o)
        else $error("closed socket accepted");
    a_multi_udp: assert property (cfg_o.multicast_enable |-> cfg_o.proto == 4'h2)
        else $error("multicast outside udp");
    a_igmp_multi: assert property (cfg_o.igmp_version_one |-> cfg_o.multicast_enable)
        else $error("igmp select without multicast");
    a_tcp_ack_pulse: assert property (ack_send_o |=> !ack_send_o)
        else $error("ack pulse too long");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !frame_accept_o
        && !frame_drop_o && !ack_send_o && cfg_o == '0)
        else $error("outputs not quiet after reset");
endmodule : smrf_socket_mode_filter_chk
bind smrf_socket_mode_filter smrf_socket_mode_filter_chk #(.CHIP_VERSION(CHIP_VERSION)) chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_valid_i(frame_valid_i),
    .frame_i(frame_i), .frame_accept_o(frame_accept_o), .frame_drop_o(frame_drop_o),
    .ack_send_o(ack_send_o), .cfg_socket_i(cfg_socket_i), .cfg_o(cfg_o)
);
`default_nettype wire

// >>> test/smrf_socket_mode_filter_tb.sv
// Self-checking bench for the socket mode filter
`timescale 1ns/10ps
`default_nettype none
module smrf_socket_mode_filter_tb;
    // ====================
    // Signals
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [11:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic frame_valid_i = 0, frame_accept_o, frame_drop_o, tcp_data_rx_i = 0, ack_send_o;
    logic [2:0] tcp_socket_i = 0, cfg_socket_i = 0, ack_socket_o;
    smrf_pkg::smrf_frame_t frame_i = '0;
    smrf_pkg::smrf_sock_cfg_t cfg_o;
    logic [47:0] own;
    logic [7:0] mv [8];
    int n_mismatch = 0, checks_done = 0, cyc_n = 0, k;
    int n_acc = 0, n_drp = 0;
    localparam logic [7:0] VER = 8'h3C; // Arbitrary identification value
    localparam logic [3:0] PR [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    smrf_socket_mode_filter #(.CHIP_VERSION(VER), .RETRY_UNIT_CYCLES(2)) smrf_socket_mode_filter_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
        .frame_accept_o(frame_accept_o), .frame_drop_o(frame_drop_o), .tcp_data_rx_i(tcp_data_rx_i),
        .tcp_socket_i(tcp_socket_i), .ack_send_o(ack_send_o), .ack_socket_o(ack_socket_o),
        .cfg_socket_i(cfg_socket_i), .cfg_o(cfg_o));
    always #5 clk_i = ~clk_i;
    // A hung handshake must still reach the verdict
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // ====================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask : wb
    function automatic logic exp_drop(input logic [7:0] m, input smrf_pkg::smrf_frame_t f);
        case (m[3:0])
            4'h1: return f.is_broadcast | f.is_multicast;
            4'h2: return (f.is_broadcast & m[6]) | (f.is_multicast & !m[7]) | (m[7] & m[4] & f.is_unicast_ip);
            4'h4: return (m[7] & !f.is_broadcast & f.dest_mac != own) | (m[6] & f.is_broadcast)
                | (m[5] & f.is_multicast) | (m[4] & f.is_ipv6);
            default: return 1'b1;
        endcase
    endfunction : exp_drop
    task automatic frame(input logic [2:0] s, input logic [7:0] m);
        smrf_pkg::smrf_frame_t f;
        logic dr;
        logic me;
        f.socket = s;
        f.dest_mac = ($urandom % 2) ? own : {16'h0000, $urandom};
        {f.is_broadcast, f.is_multicast, f.is_ipv6, f.is_unicast_ip} = 4'($urandom);
        dr = exp_drop(m, f);
        if (dr) n_drp++;
        else n_acc++;
        me = m[3:0] == 4'h2 && m[7];
        wb(1, {1'b0, s, 8'h00}, {24'h00_0000, m});
        @(posedge clk_i);
        cfg_socket_i <= s;
        @(posedge clk_i);
        frame_valid_i <= 1;
        frame_i <= f;
        @(posedge clk_i);
        frame_valid_i <= 0;
        check("cfg", cfg_o, {m[3:0], me, me & m[5]});
        @(posedge clk_i);
        check("verdict", {frame_accept_o, frame_drop_o}, {!dr, dr});
    endtask : frame
    task automatic tcp(input logic [2:0] s, output int n);
        @(posedge clk_i);
        tcp_data_rx_i <= 1;
        tcp_socket_i <= s;
        @(posedge clk_i);
        tcp_data_rx_i <= 0;
        for (n = 1; n < 40; n++) begin
            @(posedge clk_i);
            if (ack_send_o === 1'b1) break;
        end
    endtask : tcp
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // ====================
    // Sequence
    initial begin
        void'($urandom(32'hfefb));
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        for (int s = 0; s < 8; s++) begin
            wb(0, {1'b0, 3'(s), 8'h00}, 0);
            check("mode_reset", rd[7:0], 8'h00);
        end
        wb(0, 12'h0F4, 0);
        check("retry_reset", rd, 32'h0000_07D0);
        wb(1, 12'h0E4, 32'hffff_ffff);
        wb(0, 12'h0E4, 0);
        check("version", rd[7:0], VER);
        wb(0, 12'h800, 0);
        check("unmapped", rd, 0);
        $display("Test registers done");
        for (int s = 0; s < 8; s++) begin
            mv[s] = 8'($urandom);
            wb(1, {1'b0, 3'(s), 8'h00}, {24'h00_0000, mv[s]});
        end
        for (int s = 0; s < 8; s++) begin
            wb(0, {1'b0, 3'(s), 8'h00}, 0);
            check("mode_rw", rd[7:0], mv[s]);
        end
        $display("Test sockets done");
        own = {16'($urandom), $urandom};
        wb(1, 12'h0EC, own[31:0]);
        wb(1, 12'h0F0, {16'h0000, own[47:32]});
        frame(3'h5, 8'h84);
        repeat (150) frame(3'($urandom), {4'($urandom), PR[$urandom % 5]}); // Group address lives outside
        wb(0, 12'h0E8, 0);
        check("status", rd, {16'h0000, 8'(n_drp), 8'(n_acc)});
        $display("Test filter done");
        wb(1, 12'h0F4, 3);
        wb(1, 12'h200, 8'h21);
        tcp(3'h2, k);
        check("ack_fast", k, 1);
        check("ack_socket", ack_socket_o, 2);
        wb(1, 12'h200, 8'h01);
        tcp(3'h2, k);
        check("ack_slow", k, 1 + 3 * 2);
        wb(1, 12'h300, 8'h22);
        tcp(3'h3, k);
        check("ack_udp", k, 40);
        wb(1, 12'h0F4, 0);
        tcp(3'h2, k);
        check("ack_zero", k, 1);
        $display("Test ack done");
        give_verdict();
    end
endmodule : smrf_socket_mode_filter_tb
`default_nettype wire
